/* src/sbt_pkg.sv */
// Package of register map, field positions and constants for the 16-bit timer/counter
package sbt_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] SBT_CTRL_OFF = 12'h000;
  localparam logic [11:0] SBT_COUNT_OFF = 12'h004;
  localparam logic [11:0] SBT_PERIOD_OFF = 12'h008;
  localparam logic [11:0] SBT_STATUS_OFF = 12'h00c;
  localparam logic [11:0] SBT_MASK_OFF = 12'h010;
  // Control field positions
  localparam int SBT_RUN_BIT = 15;
  localparam int SBT_IDLE_BIT = 13;
  localparam int SBT_GATE_BIT = 6;
  localparam int SBT_DIV_HI = 5;
  localparam int SBT_DIV_LO = 4;
  localparam int SBT_SYNC_BIT = 2;
  localparam int SBT_SRC_BIT = 1;
  // Writable control bits; the rest read as zero
  localparam logic [15:0] SBT_CTRL_MASK = 16'ha076;
  // Reset values
  localparam logic [15:0] SBT_CTRL_RST = 16'h0000;
  localparam logic [15:0] SBT_COUNT_RST = 16'h0000;
  localparam logic [15:0] SBT_PERIOD_RST = 16'hffff;
  // Prescaler terminal counts (divide minus one)
  localparam logic [7:0] SBT_DIV1_TC = 8'h00;
  localparam logic [7:0] SBT_DIV8_TC = 8'h07;
  localparam logic [7:0] SBT_DIV64_TC = 8'h3f;
  localparam logic [7:0] SBT_DIV256_TC = 8'hff;
  // Status bit positions
  localparam int SBT_ST_PERIOD = 0;
  localparam int SBT_ST_GATE = 1;
  // Operating modes
  typedef enum logic [1:0] {
    SBT_TIMER, SBT_GATED, SBT_SYNC_CNT, SBT_ASYNC_CNT
  } sbt_mode_e;
endpackage

/* src/sbt_timer.sv */
// 16-bit timer/counter with prescaler, gating, idle halt and APB registers
// How it works
// - Sixteen bit counter, timer or event counter
// - Mode from source, gate and sync bits
// - Source bit 1, sync bit 2, gate bit 6
// - Timers use internal clock, counters use pin
// - Async counter counts pin edges without the tick crossing
// - Synchronisation happens after the prescaler
// - Bit 15 starts and stops counter
// - Bit 13 halts counter in idle
// - Gate bit ignored with external clock
// - Bits 5-4 divide by 1, 8, 64, 256
// - Sync bit ignored with internal clock
// - Source bit picks pin edges or internal
// - Count writes ignored in running sync counter
// - Unimplemented control bits read zero
// - All control bits reset to zero
`timescale 1ns/1ps
`default_nettype none
module sbt_timer (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device and pins
  input wire logic idle_mode,
  input wire logic external_count_pin,
  input wire logic gate_pin,
  // Interrupt
  output logic irq
);
  import sbt_pkg::*;

  logic [15:0] ctrl_ff, count_ff, period_ff;
  logic [1:0] status_ff, mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, irq_ff;
  logic [7:0] pre_ff;
  logic [1:0] pin_sync_ff, gate_sync_ff;
  logic pin_prev_ff, gate_prev_ff;
  logic tick_tgl_ff;
  logic [1:0] tick_sync_ff;
  logic tick_prev_ff;
  logic [31:0] nxt_prdata;
  logic [15:0] nxt_count;
  logic [1:0] nxt_status;
  logic [1:0] set_ev;

  // Control fields
  // field positions
  wire run = ctrl_ff[SBT_RUN_BIT];
  wire halt_in_idle = ctrl_ff[SBT_IDLE_BIT];
  wire gated_accumulate_enable = ctrl_ff[SBT_GATE_BIT];
  wire [1:0] input_divider_select = ctrl_ff[SBT_DIV_HI:SBT_DIV_LO];
  wire external_sync_select = ctrl_ff[SBT_SYNC_BIT];
  wire clock_source_select = ctrl_ff[SBT_SRC_BIT];

  // Mode decode
  // mode decode
  wire sbt_mode_e mode = clock_source_select ?
      (external_sync_select ? SBT_SYNC_CNT : SBT_ASYNC_CNT) :
      (gated_accumulate_enable ? SBT_GATED : SBT_TIMER);

  // Prescale terminal count decode
  function automatic logic [7:0] div_tc(input logic [1:0] sel);
    case (sel)
      2'b11: div_tc = SBT_DIV256_TC;
      2'b10: div_tc = SBT_DIV64_TC;
      2'b01: div_tc = SBT_DIV8_TC;
      default: div_tc = SBT_DIV1_TC;
    endcase
  endfunction

  // Bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == SBT_CTRL_OFF;
  wire hit_count = paddr == SBT_COUNT_OFF;
  wire hit_period = paddr == SBT_PERIOD_OFF;
  wire hit_status = paddr == SBT_STATUS_OFF;
  wire hit_mask = paddr == SBT_MASK_OFF;
  wire hit_any = hit_ctrl | hit_count | hit_period | hit_status | hit_mask;

  // Pin edges; the pin is always double registered before use
  wire pin_rise = pin_sync_ff[1] && !pin_prev_ff;
  wire gate_hi = gate_sync_ff[1];
  wire gate_fall = !gate_sync_ff[1] && gate_prev_ff;

  // Counter enable: stopped when off or halted in idle
  // run gating
  wire active = run && !(halt_in_idle && idle_mode);

  // Prescaler input: internal clock or pin edge, gate only for internal
  // source pick
  wire pre_in = !clock_source_select ? (mode == SBT_GATED ? gate_hi : 1'b1) : pin_rise;
  wire pre_out = active && pre_in && (pre_ff == div_tc(input_divider_select));

  // Synchronised counter path: prescaled tick passes a toggle crossing
  // sync after prescaler
  wire sync_tick = tick_sync_ff[1] ^ tick_prev_ff;
  // async path takes prescaled tick directly; internal ignores sync
  wire tick = (mode == SBT_SYNC_CNT) ? (sync_tick && active) : pre_out;

  // count writes blocked in running sync counter
  wire count_wr_ok = !(mode == SBT_SYNC_CNT && run);

  // Counter next value and events
  // count and wrap
  always_comb begin
    nxt_count = count_ff;
    set_ev = 2'b00;
    if (tick) begin
      if (count_ff == period_ff) begin
        nxt_count = SBT_COUNT_RST;
        set_ev[SBT_ST_PERIOD] = 1'b1;
      end else begin
        nxt_count = count_ff + 16'h0001;
      end
    end
    if (mode == SBT_GATED && active && gate_fall) begin
      set_ev[SBT_ST_GATE] = 1'b1;
    end
    if (wr && hit_count && count_wr_ok) begin
      nxt_count = pwdata[15:0];
    end
    // Write one clears, but an event in the same cycle wins, even on a bit already set
    if (wr && hit_status) begin
      nxt_status = (status_ff & ~pwdata[1:0]) | set_ev;
    end else begin
      nxt_status = status_ff | set_ev;
    end
  end

  // Read mux; unmapped reads zero with error
  // readback
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_ctrl) nxt_prdata = {16'h0000, ctrl_ff & SBT_CTRL_MASK};
    else if (hit_count) nxt_prdata = {16'h0000, count_ff};
    else if (hit_period) nxt_prdata = {16'h0000, period_ff};
    else if (hit_status) nxt_prdata = {30'h0, status_ff};
    else if (hit_mask) nxt_prdata = {30'h0, mask_ff};
  end

  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_ff <= 2'b00;
      gate_sync_ff <= 2'b00;
      pin_prev_ff <= 1'b0;
      gate_prev_ff <= 1'b0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[0], external_count_pin};
      gate_sync_ff <= {gate_sync_ff[0], gate_pin};
      pin_prev_ff <= pin_sync_ff[1];
      gate_prev_ff <= gate_sync_ff[1];
    end
  end

  // Prescaler and tick toggle; prescaler clears when stopped
  // divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 8'h00;
      tick_tgl_ff <= 1'b0;
    end else begin
      if (!active) pre_ff <= 8'h00;
      else if (pre_out) pre_ff <= 8'h00;
      else if (pre_in) pre_ff <= pre_ff + 8'h01;
      if (pre_out) tick_tgl_ff <= !tick_tgl_ff;
    end
  end

  // Toggle crossing stage: the first flop is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_sync_ff <= 2'b00;
      tick_prev_ff <= 1'b0;
    end else begin
      tick_sync_ff <= {tick_sync_ff[0], tick_tgl_ff};
      tick_prev_ff <= tick_sync_ff[1];
    end
  end

  // Registers
  // reset to zero, except period, which resets to ffff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= SBT_CTRL_RST;
      count_ff <= SBT_COUNT_RST;
      period_ff <= SBT_PERIOD_RST;
      status_ff <= 2'b00;
      mask_ff <= 2'b00;
    end else begin
      if (wr && hit_ctrl) ctrl_ff <= pwdata[15:0] & SBT_CTRL_MASK;
      if (wr && hit_period) period_ff <= pwdata[15:0];
      if (wr && hit_mask) mask_ff <= pwdata[1:0];
      count_ff <= nxt_count;
      status_ff <= nxt_status;
    end
  end

  // Bus answer and interrupt, all registered; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !hit_any;
      prdata_ff <= nxt_prdata;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

  // count writes blocked when sync counter runs
  property p_count_wr_block;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_count && mode == SBT_SYNC_CNT && run && !tick) |=> $stable(count_ff);
  endproperty
  a_count_wr_block: assert property (p_count_wr_block) else $error("count write not blocked");

  property p_ctrl_res;
    @(posedge pclk) disable iff (!presetn) (ctrl_ff & ~SBT_CTRL_MASK) == 16'h0000;
  endproperty
  a_ctrl_res: assert property (p_ctrl_res) else $error("reserved control bit set");

  property p_stop;
    @(posedge pclk) disable iff (!presetn) (!run && !(wr && hit_count)) |=> $stable(count_ff);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
      (halt_in_idle && idle_mode && mode != SBT_SYNC_CNT && !(wr && hit_count))
      |=> $stable(count_ff);
  endproperty
  a_idle: assert property (p_idle) else $error("counter ran in idle");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (tick && count_ff == period_ff && !(wr && hit_count))
      |=> (count_ff == 16'h0000 && status_ff[SBT_ST_PERIOD]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("period wrap failed");

  // divide by one in timer mode counts every cycle
  property p_div1;
    @(posedge pclk) disable iff (!presetn)
      (active && mode == SBT_TIMER && input_divider_select == 2'b00 && count_ff != period_ff
       && !(wr && (hit_count || hit_ctrl))) |=> count_ff == $past(count_ff) + 16'h0001;
  endproperty
  a_div1: assert property (p_div1) else $error("1:1 prescale wrong");

  // gated mode stalls while gate low
  property p_gate_low;
    @(posedge pclk) disable iff (!presetn)
      (mode == SBT_GATED && !gate_hi) |-> !tick;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("count with gate low");

  // async counter ticks only on pin edges
  property p_async;
    @(posedge pclk) disable iff (!presetn)
      (mode == SBT_ASYNC_CNT && tick) |-> pin_rise;
  endproperty
  a_async: assert property (p_async) else $error("async tick without pin edge");

  // sync counter tick lands three cycles after the prescaler
  sequence s_pre_sync;
    pre_out && mode == SBT_SYNC_CNT;
  endsequence
  property p_sync_lat;
    @(posedge pclk) disable iff (!presetn) s_pre_sync |-> ##3 sync_tick;
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("sync tick latency wrong");

  // internal source ignores the sync bit
  property p_sync_ignored;
    @(posedge pclk) disable iff (!presetn)
      !clock_source_select |-> (tick == pre_out);
  endproperty
  a_sync_ignored: assert property (p_sync_ignored) else $error("sync bit used on internal");

  // external source moves only on pin edges
  property p_pin_only;
    @(posedge pclk) disable iff (!presetn)
      (clock_source_select && !pin_rise) |-> !pre_out;
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("prescaler moved without pin edge");

  // internal timer at 1:1 ticks every cycle while running
  property p_int_src;
    @(posedge pclk) disable iff (!presetn)
      (active && mode == SBT_TIMER && input_divider_select == 2'b00) |-> tick;
  endproperty
  a_int_src: assert property (p_int_src) else $error("internal clock tick missing");

  // gate fall raises its status flag
  property p_gate_flag;
    @(posedge pclk) disable iff (!presetn)
      (mode == SBT_GATED && active && gate_fall) |=> status_ff[SBT_ST_GATE];
  endproperty
  a_gate_flag: assert property (p_gate_flag) else $error("gate fall not flagged");

  // setup cycle is answered in the next cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");

  // unmapped address answers with an error
  property p_slverr;
    @(posedge pclk) disable iff (!presetn) (psel && !penable && !hit_any) |=> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no error on unmapped");

  // a pending unmasked event keeps the interrupt up
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (|(status_ff & mask_ff) && !(wr && (hit_status || hit_mask))) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule
`default_nettype wire

/* verif/sbt_pin_model.sv */
// Model of the external count pin and the gate level driven by the far side
`timescale 1ns/1ps
`default_nettype none
module sbt_pin_model (
  // Clock
  input wire logic pclk,
  // Pins
  output logic count_pin,
  output logic gate_lvl
);
  initial begin
    count_pin = 1'b0;
    gate_lvl = 1'b0;
  end
  // rising pin edges
  // Each level is held at least four cycles so the two-flop stage cannot miss it
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic set_gate(input logic v);
    @(posedge pclk) gate_lvl <= v;
  endtask
endmodule
`default_nettype wire

/* verif/sixteen_bit_timer_counter_test.sv */
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_counter_test;
  import sbt_pkg::*;
  typedef struct {logic [31:0] lo; logic [31:0] hi;} sbt_exp_s;
  logic pclk, presetn, psel, penable, pwrite, idle_mode, pready, pslverr, irq;
  logic ext_pin, gate_lvl, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  sbt_exp_s exp_q[$];
  sbt_exp_s e;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'hf574;
  int dv;
  sbt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .external_count_pin(ext_pin),
    .gate_pin(gate_lvl), .irq(irq));
  sbt_pin_model pin (.pclk(pclk), .count_pin(ext_pin), .gate_lvl(gate_lvl));
  // Clock at 200 MHz
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Range compare; an unknown never counts as inside the range
  task automatic chk(input string n, input logic [31:0] lo, hi, s);
    samples_checked++;
    if ((s >= lo && s <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR %s expected %h..%h seen %h", n, lo, hi, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  // Only the hang guard ends a wait for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] lo, hi);
    exp_q.push_back('{lo, hi});
    apb(1'b0, a, 32'h0);
  endtask
  // Watcher takes the oldest note whenever read data is returned
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("read data", e.lo, e.hi, prdata);
    end
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    idle_mode = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(SBT_CTRL_OFF, 32'h0, 32'h0);
    rd(SBT_COUNT_OFF, 32'h0, 32'h0);
    rd(SBT_PERIOD_OFF, 32'hffff, 32'hffff);
    rd(SBT_STATUS_OFF, 32'h0, 32'h0);
    wr(SBT_CTRL_OFF, 32'hffff);
    rd(SBT_CTRL_OFF, 32'ha076, 32'ha076);
    wr(SBT_CTRL_OFF, 32'h0);
    rnd = $random(seed);
    wr(12'h014, rnd);
    chk("write error", 1'b1, 1'b1, last_err);
    rd(12'h014, 32'h0, 32'h0);
    $display("test registers done");
    // Each divide runs about 512 cycles; latency slack of three counts
    for (int i = 0; i < 4; i++) begin
      dv = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : 256;
      wr(SBT_COUNT_OFF, 32'h0);
      wr(SBT_CTRL_OFF, 32'h8000 | (i << 4));
      repeat (509) @(posedge pclk);
      wr(SBT_CTRL_OFF, 32'h0);
      rd(SBT_COUNT_OFF, (512 / dv > 3) ? 512 / dv - 3 : 0, 512 / dv + 3);
      rd(SBT_COUNT_OFF, (512 / dv > 3) ? 512 / dv - 3 : 0, 512 / dv + 3);
    end
    $display("test prescale done");
    wr(SBT_COUNT_OFF, 32'h0);
    @(posedge pclk) idle_mode <= 1'b1;
    wr(SBT_CTRL_OFF, 32'ha000);
    repeat (100) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'h0, 32'h0);
    wr(SBT_CTRL_OFF, 32'h8000);
    repeat (100) @(posedge pclk);
    wr(SBT_CTRL_OFF, 32'h0);
    rd(SBT_COUNT_OFF, 32'd98, 32'd112);
    @(posedge pclk) idle_mode <= 1'b0;
    $display("test idle done");
    wr(SBT_COUNT_OFF, 32'h0);
    wr(SBT_PERIOD_OFF, 32'h9);
    wr(SBT_CTRL_OFF, 32'h8000);
    repeat (40) @(posedge pclk);
    wr(SBT_CTRL_OFF, 32'h0);
    rd(SBT_STATUS_OFF, 32'h1, 32'h1);
    rd(SBT_COUNT_OFF, 32'h0, 32'h9);
    chk("irq masked", 1'b0, 1'b0, irq);
    wr(SBT_MASK_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", 1'b1, 1'b1, irq);
    wr(SBT_STATUS_OFF, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 1'b0, 1'b0, irq);
    rd(SBT_STATUS_OFF, 32'h0, 32'h0);
    wr(SBT_PERIOD_OFF, 32'hffff);
    $display("test period and interrupt done");
    wr(SBT_COUNT_OFF, 32'h0);
    wr(SBT_CTRL_OFF, 32'h8040);
    repeat (50) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'h0, 32'h0);
    pin.set_gate(1'b1);
    repeat (100) @(posedge pclk);
    pin.set_gate(1'b0);
    repeat (10) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'd96, 32'd105);
    rd(SBT_STATUS_OFF, 32'h2, 32'h2);
    wr(SBT_CTRL_OFF, 32'h0);
    wr(SBT_STATUS_OFF, 32'h3);
    $display("test gate done");
    wr(SBT_COUNT_OFF, 32'h0);
    wr(SBT_CTRL_OFF, 32'h8046);
    pin.pulse(10);
    repeat (20) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'd10, 32'd10);
    wr(SBT_COUNT_OFF, rnd & 32'hffff);
    rd(SBT_COUNT_OFF, 32'd10, 32'd10);
    wr(SBT_CTRL_OFF, 32'h0);
    wr(SBT_COUNT_OFF, 32'h0);
    wr(SBT_CTRL_OFF, 32'h8016);
    pin.pulse(16);
    repeat (20) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'd2, 32'd2);
    wr(SBT_CTRL_OFF, 32'h0);
    wr(SBT_COUNT_OFF, 32'h0);
    wr(SBT_CTRL_OFF, 32'h8002);
    pin.pulse(5);
    repeat (20) @(posedge pclk);
    rd(SBT_COUNT_OFF, 32'd5, 32'd5);
    $display("test external done");
    close_out();
  end
endmodule
`default_nettype wire
